// File: hdl/cabe_pkg.sv
// shared constants and types of the execute block
package cabe_pkg;

  localparam int unsigned DATA_WIDTH  = 8;
  localparam int unsigned WORD_WIDTH  = 16;
  localparam int unsigned OFFS_WIDTH  = 12;
  localparam int unsigned IMMW_WIDTH  = 6;
  localparam int unsigned CYC_WIDTH   = 3;

  // status register bit positions
  localparam int unsigned FLAG_C      = 0;
  localparam int unsigned FLAG_Z      = 1;
  localparam int unsigned FLAG_N      = 2;
  localparam int unsigned FLAG_V      = 3;
  localparam int unsigned FLAG_S      = 4;
  localparam int unsigned FLAG_H      = 5;
  localparam int unsigned FLAG_I      = 7;

  localparam logic [7:0] ALL_ONES     = 8'hFF;
  localparam logic [7:0] ALL_ZERO     = 8'h00;
  localparam logic [7:0] ONE_BYTE     = 8'h01;
  localparam logic [7:0] NONE_MASK    = 8'h00;

  // flag update masks
  localparam logic [7:0] MASK_ARITH   = 8'h2F;  // h v n z c
  localparam logic [7:0] MASK_WORD    = 8'h1F;  // s v n z c
  localparam logic [7:0] MASK_LOGIC   = 8'h0E;  // v n z
  localparam logic [7:0] MASK_INVERT  = 8'h0F;  // v n z c
  localparam logic [7:0] MASK_IEXIT   = 8'h80;  // i

  // cycle counts
  localparam logic [2:0] CYC_ONE      = 3'h1;
  localparam logic [2:0] CYC_TWO      = 3'h2;
  localparam logic [2:0] CYC_THREE    = 3'h3;
  localparam logic [2:0] CYC_FOUR     = 3'h4;

  // program counter steps
  localparam int unsigned STEP_NEXT   = 1;
  localparam int unsigned STEP_SKIP1  = 2;
  localparam int unsigned STEP_SKIP2  = 3;

  typedef enum logic [5:0] {
    op_reg_sum, op_carry_sum, word_immediate_sum,
    op_reg_difference, immediate_difference, borrow_difference, immediate_borrow_difference,
    word_immediate_difference,
    op_reg_conjunction, masked_constant_conjunction, op_reg_disjunction, constant_disjunction,
    exclusive_disjunction, bitwise_invert, twos_inverse, set_bits_mask, clear_bits_mask,
    op_plus_one, minus_one, zero_sign_test, zero_register, all_ones_register,
    relative_jump, pointer_jump, relative_call, pointer_call, subroutine_exit, interrupt_exit,
    equal_skip, register_compare, carry_compare, immediate_compare, bit_clear_skip,
    op_none
  } cabe_op_type;

  typedef enum logic [2:0] {
    fn_sum, fn_difference, fn_conjunction, fn_disjunction, fn_exclusive, fn_invert, fn_pass
  } cabe_fn_type;

  typedef struct packed {
    cabe_op_type             op;
    logic [DATA_WIDTH-1:0]   dst;       // destination register value
    logic [DATA_WIDTH-1:0]   src;       // source register value
    logic [DATA_WIDTH-1:0]   imm;       // byte constant or mask
    logic [IMMW_WIDTH-1:0]   word_imm;  // constant for register pair ops
    logic [WORD_WIDTH-1:0]   pair;      // register pair value
    logic [OFFS_WIDTH-1:0]   offset;    // signed relative offset
    logic [2:0]              bit_sel;
    logic                    next_long; // instruction after this one is two words
  } cabe_request_type;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } cabe_flags_type;

endpackage : cabe_pkg

// File: hdl/cabe_alu.sv
// byte arithmetic and logic unit with status flag generation
`timescale 1ns/1ps
module cabe_alu
  import cabe_pkg::*;
(
  input  wire cabe_fn_type     fn,
  input  wire logic [7:0]      a,
  input  wire logic [7:0]      b,
  input  wire logic            carry_in,
  output logic [7:0]           result,
  output cabe_flags_type       flags
);

  logic [8:0] full;
  logic [4:0] half;
  logic [7:0] b_eff;
  logic       cin_eff;
  logic       is_diff;

  // subtraction is a + ~b + ~borrow, then carry is inverted to read as borrow
  always_comb begin
    is_diff = (fn == fn_difference);
    b_eff   = is_diff ? ~b : b;
    cin_eff = is_diff ? ~carry_in : carry_in;
    full    = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
    half    = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
  end

  always_comb begin
    result  = ALL_ZERO;
    flags   = '0;
    case (fn)
      fn_sum, fn_difference: begin
        result  = full[7:0];
        flags.c = is_diff ? ~full[8] : full[8];
        flags.h = is_diff ? ~half[4] : half[4];
        flags.v = (a[7] == b_eff[7]) && (result[7] != a[7]);
      end
      fn_conjunction: result = a & b;
      fn_disjunction: result = a | b;
      fn_exclusive:   result = a ^ b;
      fn_invert: begin
        result  = ALL_ONES - a;
        flags.c = 1'b1;
      end
      fn_pass:        result = b;
      default:        result = ALL_ZERO;
    endcase
    flags.n = result[7];
    flags.z = (result == ALL_ZERO);
    flags.s = flags.n ^ flags.v;
  end

endmodule : cabe_alu

// File: hdl/cabe_exec.sv
// execute stage for arithmetic, logic, compare, skip and jump/call instructions
`timescale 1ns/1ps
// What this block does
// - register sum, optionally plus carry, written in one cycle; z c n v h updated
// - pair plus constant written in two cycles; z c n v s updated
// - register or constant difference stored in one cycle; z c n v h updated
// - register minus source minus carry stored in one cycle; z c n v h updated
// - register minus constant minus carry stored in one cycle; z c n v h updated
// - pair minus constant written in two cycles; z c n v s updated
// - and with register or constant in one cycle; only z n v updated
// - or with register or constant in one cycle; only z n v updated
// - exclusive or of registers in one cycle; only z n v updated
// - invert gives ff minus value in one cycle; z c n v updated
// - set bits ors a mask in one cycle; z n v updated
// - clear bits ands inverted mask in one cycle; z n v updated
// - increment by one in one cycle; z n v updated, carry kept
// - decrement by one in one cycle; z n v updated, carry kept
// - test ands register with itself in one cycle; value kept; z n v updated
// - clear exclusive-ors register with itself in one cycle; z n v updated
// - relative jump and call load pc plus offset plus one; two and three cycles
// - pointer jump loads pc from z pair in two cycles, no flags
// - pointer call loads pc from z pair in three cycles, no flags
// - equal skip steps pc by two or three when equal; one or two cycles
// - compares set z n v c h without storing, in one cycle
// - bit clear skip skips when selected bit is zero; one or two cycles, no flags
module cabe_exec
  import cabe_pkg::*;
#(
  parameter int unsigned PC_WIDTH = WORD_WIDTH
)(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire cabe_request_type      req,
  input  wire logic [7:0]            status_in,
  input  wire logic [PC_WIDTH-1:0]   pc_in,
  input  wire logic [WORD_WIDTH-1:0] z_pointer,
  input  wire logic [PC_WIDTH-1:0]   stack_top,
  output logic                       busy,
  output logic                       done,
  output logic                       dst_we,
  output logic [7:0]                 dst_value,
  output logic                       pair_we,
  output logic [WORD_WIDTH-1:0]      pair_value,
  output logic                       status_we,
  output logic [7:0]                 status_value,
  output logic                       pc_we,
  output logic [PC_WIDTH-1:0]        pc_value,
  output logic                       push_we,
  output logic [PC_WIDTH-1:0]        push_value,
  output logic                       pop_req
);

  if (PC_WIDTH < OFFS_WIDTH || PC_WIDTH > WORD_WIDTH) begin : g_check
    $error("cabe_exec: PC_WIDTH must lie between offset width and word width");
  end

  cabe_fn_type    fn;
  logic [7:0]     alu_a;
  logic [7:0]     alu_b;
  logic           alu_cin;
  logic [7:0]     alu_res;
  cabe_flags_type alu_flags;

  cabe_alu u_alu (
    .fn       (fn),
    .a        (alu_a),
    .b        (alu_b),
    .carry_in (alu_cin),
    .result   (alu_res),
    .flags    (alu_flags)
  );

  logic                  carry_old;
  logic [WORD_WIDTH-1:0] word_res;
  cabe_flags_type        word_flags;
  logic                  skip_taken;
  logic [PC_WIDTH-1:0]   pc_rel;
  logic [PC_WIDTH-1:0]   pc_skip;

  assign carry_old = status_in[FLAG_C];

  // operand routing onto the byte unit
  always_comb begin
    fn      = fn_pass;
    alu_a   = req.dst;
    alu_b   = req.src;
    alu_cin = 1'b0;
    case (req.op)
      op_reg_sum:                  fn = fn_sum;
      op_carry_sum: begin
        fn      = fn_sum;
        alu_cin = carry_old;
      end
      op_reg_difference, register_compare: fn = fn_difference;
      immediate_difference, immediate_compare: begin
        fn    = fn_difference;
        alu_b = req.imm;
      end
      borrow_difference, carry_compare: begin
        fn      = fn_difference;
        alu_cin = carry_old;
      end
      immediate_borrow_difference: begin
        fn      = fn_difference;
        alu_b   = req.imm;
        alu_cin = carry_old;
      end
      op_reg_conjunction:          fn = fn_conjunction;
      masked_constant_conjunction: begin
        fn    = fn_conjunction;
        alu_b = req.imm;
      end
      op_reg_disjunction:          fn = fn_disjunction;
      constant_disjunction, set_bits_mask: begin
        fn    = fn_disjunction;
        alu_b = req.imm;
      end
      exclusive_disjunction:       fn = fn_exclusive;
      bitwise_invert:              fn = fn_invert;
      twos_inverse: begin
        fn    = fn_difference;
        alu_a = ALL_ZERO;
        alu_b = req.dst;
      end
      clear_bits_mask: begin
        fn    = fn_conjunction;
        alu_b = ALL_ONES - req.imm;
      end
      op_plus_one: begin
        fn    = fn_sum;
        alu_b = ONE_BYTE;
      end
      minus_one: begin
        fn    = fn_difference;
        alu_b = ONE_BYTE;
      end
      zero_sign_test: begin
        fn    = fn_conjunction;
        alu_b = req.dst;
      end
      zero_register: begin
        fn    = fn_exclusive;
        alu_b = req.dst;
      end
      all_ones_register: begin
        fn    = fn_pass;
        alu_b = ALL_ONES;
      end
      default:                     fn = fn_pass;
    endcase
  end

  // register pair arithmetic, flags v c n taken from the top bits of the pair, z from the whole result
  always_comb begin
    word_flags = '0;
    if (req.op == word_immediate_difference) begin
      word_res     = req.pair - {{(WORD_WIDTH-IMMW_WIDTH){1'b0}}, req.word_imm};
      word_flags.v = req.pair[WORD_WIDTH-1] & ~word_res[WORD_WIDTH-1];
      word_flags.c = word_res[WORD_WIDTH-1] & ~req.pair[WORD_WIDTH-1];
    end else begin
      word_res     = req.pair + {{(WORD_WIDTH-IMMW_WIDTH){1'b0}}, req.word_imm};
      word_flags.v = ~req.pair[WORD_WIDTH-1] & word_res[WORD_WIDTH-1];
      word_flags.c = ~word_res[WORD_WIDTH-1] & req.pair[WORD_WIDTH-1];
    end
    word_flags.n = word_res[WORD_WIDTH-1];
    word_flags.z = (word_res == '0);
    word_flags.s = word_flags.n ^ word_flags.v;
  end

  // program counter targets
  always_comb begin
    pc_rel  = pc_in + {{(PC_WIDTH-OFFS_WIDTH){req.offset[OFFS_WIDTH-1]}}, req.offset}
              + PC_WIDTH'(STEP_NEXT);
    pc_skip = pc_in + (req.next_long ? PC_WIDTH'(STEP_SKIP2) : PC_WIDTH'(STEP_SKIP1));
    case (req.op)
      equal_skip:     skip_taken = (req.dst == req.src);
      bit_clear_skip: skip_taken = ~req.src[req.bit_sel];
      default:        skip_taken = 1'b0;
    endcase
  end

  // complete effect of the request, computed as it is accepted
  logic                  c_dst_we;
  logic                  c_pair_we;
  logic [7:0]            c_mask;
  logic [7:0]            c_flag_bits;
  logic                  c_pc_we;
  logic [PC_WIDTH-1:0]   c_pc;
  logic                  c_push;
  logic                  c_pop;
  logic [2:0]            c_cycles;

  always_comb begin
    c_dst_we    = 1'b0;
    c_pair_we   = 1'b0;
    c_mask      = NONE_MASK;
    c_pc_we     = 1'b0;
    c_pc        = pc_in;
    c_push      = 1'b0;
    c_pop       = 1'b0;
    c_cycles    = CYC_ONE;
    c_flag_bits = {2'b00, alu_flags.h, alu_flags.s, alu_flags.v, alu_flags.n, alu_flags.z, alu_flags.c};
    case (req.op)
      op_reg_sum, op_carry_sum, op_reg_difference, immediate_difference, borrow_difference,
      immediate_borrow_difference, twos_inverse: begin
        c_dst_we = 1'b1;
        c_mask   = MASK_ARITH;
      end
      register_compare, carry_compare, immediate_compare: c_mask = MASK_ARITH;
      word_immediate_sum, word_immediate_difference: begin
        c_pair_we   = 1'b1;
        c_mask      = MASK_WORD;
        c_cycles    = CYC_TWO;
        c_flag_bits = {3'b000, word_flags.s, word_flags.v, word_flags.n, word_flags.z, word_flags.c};
      end
      op_reg_conjunction, masked_constant_conjunction, op_reg_disjunction, constant_disjunction,
      exclusive_disjunction, set_bits_mask, clear_bits_mask, op_plus_one, minus_one,
      zero_register: begin
        c_dst_we = 1'b1;
        c_mask   = MASK_LOGIC;
      end
      zero_sign_test:    c_mask = MASK_LOGIC;
      bitwise_invert: begin
        c_dst_we = 1'b1;
        c_mask   = MASK_INVERT;
      end
      all_ones_register: c_dst_we = 1'b1;
      relative_jump, relative_call: begin
        c_pc_we  = 1'b1;
        c_pc     = pc_rel;
        c_push   = (req.op == relative_call);
        c_cycles = c_push ? CYC_THREE : CYC_TWO;
      end
      pointer_jump, pointer_call: begin
        c_pc_we  = 1'b1;
        c_pc     = z_pointer[PC_WIDTH-1:0];
        c_push   = (req.op == pointer_call);
        c_cycles = c_push ? CYC_THREE : CYC_TWO;
      end
      subroutine_exit, interrupt_exit: begin
        c_pc_we     = 1'b1;
        c_pc        = stack_top;
        c_pop       = 1'b1;
        c_cycles    = CYC_FOUR;
        c_mask      = (req.op == interrupt_exit) ? MASK_IEXIT : NONE_MASK;
        c_flag_bits = MASK_IEXIT;
      end
      equal_skip, bit_clear_skip: begin
        c_pc_we  = skip_taken;
        c_pc     = pc_skip;
        c_cycles = skip_taken ? CYC_TWO : CYC_ONE;
      end
      default:           c_cycles = CYC_ONE;
    endcase
  end

  // held effect for multi-cycle requests; written out on the last cycle
  logic                  accept;
  logic                  finish_now;
  logic                  finish_late;
  logic [2:0]            remain_q;
  logic                  h_dst_we_q;
  logic [7:0]            h_dst_q;
  logic                  h_pair_we_q;
  logic [WORD_WIDTH-1:0] h_pair_q;
  logic [7:0]            h_status_q;
  logic                  h_status_we_q;
  logic                  h_pc_we_q;
  logic [PC_WIDTH-1:0]   h_pc_q;
  logic                  h_push_q;
  logic                  h_pop_q;
  logic [7:0]            c_status;

  // a start while busy is ignored; the issuer is expected to wait
  assign accept      = start && !busy;
  assign finish_now  = accept && (c_cycles == CYC_ONE);
  assign finish_late = busy && (remain_q == CYC_ONE);
  // unmasked status bits pass through, so carry survives increment and decrement
  assign c_status    = (status_in & ~c_mask) | (c_flag_bits & c_mask);

  always_ff @(posedge clock) begin
    if (reset) begin
      busy     <= 1'b0;
      remain_q <= CYC_ONE;
    end else if (accept && !finish_now) begin
      busy     <= 1'b1;
      remain_q <= c_cycles - CYC_ONE;
    end else if (busy) begin
      busy     <= !finish_late;
      remain_q <= remain_q - CYC_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      h_dst_we_q    <= 1'b0;
      h_dst_q       <= ALL_ZERO;
      h_pair_we_q   <= 1'b0;
      h_pair_q      <= '0;
      h_status_we_q <= 1'b0;
      h_status_q    <= ALL_ZERO;
      h_pc_we_q     <= 1'b0;
      h_pc_q        <= '0;
      h_push_q      <= 1'b0;
      h_pop_q       <= 1'b0;
    end else if (accept) begin
      h_dst_we_q    <= c_dst_we;
      h_dst_q       <= alu_res;
      h_pair_we_q   <= c_pair_we;
      h_pair_q      <= word_res;
      h_status_we_q <= (c_mask != NONE_MASK);
      h_status_q    <= c_status;
      h_pc_we_q     <= c_pc_we;
      h_pc_q        <= c_pc;
      h_push_q      <= c_push;
      h_pop_q       <= c_pop;
    end
  end

  // write strobes are single-cycle pulses; values stay until the next finish, push_value until the next accept
  always_ff @(posedge clock) begin
    if (reset) begin
      done         <= 1'b0;
      dst_we       <= 1'b0;
      pair_we      <= 1'b0;
      status_we    <= 1'b0;
      pc_we        <= 1'b0;
      push_we      <= 1'b0;
      pop_req      <= 1'b0;
      dst_value    <= ALL_ZERO;
      pair_value   <= '0;
      status_value <= ALL_ZERO;
      pc_value     <= '0;
      push_value   <= '0;
    end else begin
      done      <= finish_now || finish_late;
      dst_we    <= finish_now ? c_dst_we : (finish_late && h_dst_we_q);
      pair_we   <= finish_late && h_pair_we_q;
      status_we <= finish_now ? (c_mask != NONE_MASK) : (finish_late && h_status_we_q);
      pc_we     <= finish_now ? c_pc_we : (finish_late && h_pc_we_q);
      push_we   <= finish_late && h_push_q;
      pop_req   <= finish_late && h_pop_q;
      if (finish_now) begin
        dst_value    <= alu_res;
        status_value <= c_status;
        pc_value     <= c_pc;
      end else if (finish_late) begin
        dst_value    <= h_dst_q;
        pair_value   <= h_pair_q;
        status_value <= h_status_q;
        pc_value     <= h_pc_q;
      end
      // return address is the word after the call
      if (accept) begin
        push_value <= pc_in + PC_WIDTH'(STEP_NEXT);
      end
    end
  end

endmodule : cabe_exec

// File: sim/cabe_far_model.sv
// far-side model: status register and instruction fetch counter
`timescale 1ns/1ps
module cabe_far_model
  import cabe_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        load_en,
  input  wire logic [7:0]  load_status,
  input  wire logic        done,
  input  wire logic        status_we,
  input  wire logic [7:0]  status_value,
  input  wire logic        pc_we,
  input  wire logic [15:0] pc_value,
  output logic [7:0]       status_q,
  output logic [15:0]      pc_q
);
  always_ff @(posedge clock) begin
    if (reset) status_q <= 8'h00;
    else if (load_en) status_q <= load_status;
    else if (status_we) status_q <= status_value;
  end
  // fetch steps by itself unless the block redirects it
  always_ff @(posedge clock) begin
    if (reset) pc_q <= 16'h0100;
    else if (pc_we) pc_q <= pc_value;
    else if (done) pc_q <= pc_q + 16'h0001;
  end
endmodule : cabe_far_model

// File: sim/cabe_exec_monitor.sv
// port checks of the execute block
`timescale 1ns/1ps
module cabe_exec_monitor
  import cabe_pkg::*;
#(
  parameter int unsigned PC_WIDTH = WORD_WIDTH
)(
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic                  start,
  input wire cabe_request_type      req,
  input wire logic [7:0]            status_in,
  input wire logic [PC_WIDTH-1:0]   pc_in,
  input wire logic [PC_WIDTH-1:0]   stack_top,
  input wire logic                  busy,
  input wire logic                  done,
  input wire logic                  dst_we,
  input wire logic [7:0]            dst_value,
  input wire logic [WORD_WIDTH-1:0] pair_value,
  input wire logic                  status_we,
  input wire logic [7:0]            status_value,
  input wire logic                  pc_we,
  input wire logic [PC_WIDTH-1:0]   pc_value,
  input wire logic [PC_WIDTH-1:0]   push_value,
  input wire logic                  pop_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic acc;
  assign acc = start && !busy;
  a_sum_single: assert property (acc && req.op == op_carry_sum |=> done && dst_we
    && dst_value == $past(req.dst) + $past(req.src) + $past(status_in[FLAG_C])) else $error("sum result");
  a_word_sum: assert property (acc && req.op == word_immediate_sum |=> busy && !done ##1 done
    && pair_value == $past(req.pair, 2) + $past(req.word_imm, 2)) else $error("word sum");
  a_call_seq: assert property (acc && req.op == relative_call |=> busy[*2] ##1 done
    && push_value == $past(pc_in, 3) + 16'h0001) else $error("call sequence");
  a_exit_seq: assert property (acc && req.op == interrupt_exit |=> !done[*3] ##1 done && pop_req
    && pc_value == $past(stack_top, 4) && status_value[FLAG_I]) else $error("exit sequence");
  a_inc_carry: assert property (acc && req.op == op_plus_one |=> dst_value == $past(req.dst) + 8'h01
    && status_value[FLAG_C] == $past(status_in[FLAG_C])) else $error("increment");
  a_cmp_keep: assert property (acc && req.op == carry_compare |=> done && !dst_we && status_we)
    else $error("compare wrote register");
  a_xor_value: assert property (acc && req.op == exclusive_disjunction |=>
    dst_value == ($past(req.dst) ^ $past(req.src)) && !status_value[FLAG_V]) else $error("xor");
  a_skip_long: assert property (acc && req.op == equal_skip && req.dst == req.src && req.next_long
    |=> ##1 done && pc_we && pc_value == $past(pc_in, 2) + 16'h0003) else $error("skip");
endmodule : cabe_exec_monitor

bind cabe_exec cabe_exec_monitor #(.PC_WIDTH(PC_WIDTH)) mon_u (.clock(clock), .reset(reset), .start(start),
  .req(req), .status_in(status_in), .pc_in(pc_in), .stack_top(stack_top), .busy(busy), .done(done),
  .dst_we(dst_we), .dst_value(dst_value), .pair_value(pair_value), .status_we(status_we),
  .status_value(status_value), .pc_we(pc_we), .pc_value(pc_value), .push_value(push_value), .pop_req(pop_req));

// File: sim/cabe_exec_tb.sv
// self-checking bench of the execute block
`timescale 1ns/1ps
module cabe_exec_tb
  import cabe_pkg::*;
;
  logic             clock = 1'b0;
  logic             reset = 1'b1;
  logic             start = 1'b0;
  logic             load_en = 1'b0;
  logic [7:0]       load_status = 8'h00;
  cabe_request_type req = '0;
  logic [15:0]      z_pointer = 16'h0000;
  logic [15:0]      stack_top = 16'h0000;
  logic             busy, done, dst_we, pair_we, status_we, pc_we, push_we, pop_req;
  logic [7:0]       dst_value, status_value, status_q, st0;
  logic [15:0]      pair_value, pc_value, push_value, pc_q, pc0;
  int               n_fail = 0;
  int               checked = 0;
  int               cyc;
  always #12.5 clock = ~clock;
  cabe_exec dut_u (.clock(clock), .reset(reset), .start(start), .req(req), .status_in(status_q), .pc_in(pc_q),
    .z_pointer(z_pointer), .stack_top(stack_top), .busy(busy), .done(done), .dst_we(dst_we),
    .dst_value(dst_value), .pair_we(pair_we), .pair_value(pair_value), .status_we(status_we),
    .status_value(status_value), .pc_we(pc_we), .pc_value(pc_value), .push_we(push_we),
    .push_value(push_value), .pop_req(pop_req));
  cabe_far_model far_u (.clock(clock), .reset(reset), .load_en(load_en), .load_status(load_status),
    .done(done), .status_we(status_we), .status_value(status_value), .pc_we(pc_we), .pc_value(pc_value),
    .status_q(status_q), .pc_q(pc_q));
  task automatic stop_test();
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic set_status(input logic [7:0] v);
    @(posedge clock);
    #1;
    load_en = 1'b1;
    load_status = v;
    @(posedge clock);
    #1;
    load_en = 1'b0;
  endtask : set_status
  // one start pulse, then a bounded wait for done; inputs captured at the accept edge
  task automatic issue(input int n);
    @(posedge clock);
    #1;
    start = 1'b1;
    pc0 = pc_q;
    st0 = status_q;
    @(posedge clock);
    #1;
    start = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 8) begin
      @(posedge clock);
      #1;
      cyc++;
    end
    if (done !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    cmp("cycles", 16'(n), 16'(cyc));
  endtask : issue
  task automatic ad(input logic [7:0] a, b, input logic ci, sub, output logic [7:0] r, output logic c, h, v);
    logic [8:0] t;
    logic [4:0] l;
    t = {1'b0, a} + {1'b0, b ^ {8{sub}}} + 9'(ci ^ sub);
    l = {1'b0, a[3:0]} + {1'b0, b[3:0] ^ {4{sub}}} + 5'(ci ^ sub);
    r = t[7:0];
    c = t[8] ^ sub;
    h = l[4] ^ sub;
    v = (a[7] == (b[7] ^ sub)) && (r[7] != a[7]);
  endtask : ad
  task automatic byte_op(input cabe_op_type o, input logic [7:0] d, s, k);
    logic [7:0] r, m, e;
    logic       c, h, v, w;
    req.op = o;
    req.dst = d;
    req.src = s;
    req.imm = k;
    issue(1);
    c = st0[0];
    w = !(o inside {carry_compare, zero_sign_test});
    h = 1'b0;
    v = 1'b0;
    m = MASK_LOGIC;
    case (o)
      op_carry_sum: ad(d, s, st0[0], 1'b0, r, c, h, v);
      borrow_difference, carry_compare: ad(d, s, st0[0], 1'b1, r, c, h, v);
      immediate_borrow_difference: ad(d, k, st0[0], 1'b1, r, c, h, v);
      op_reg_difference: ad(d, s, 1'b0, 1'b1, r, c, h, v);
      twos_inverse: ad(8'h00, d, 1'b0, 1'b1, r, c, h, v);
      masked_constant_conjunction: r = d & k;
      constant_disjunction, set_bits_mask: r = d | k;
      exclusive_disjunction: r = d ^ s;
      clear_bits_mask: r = d & ~k;
      zero_register: r = 8'h00;
      bitwise_invert: r = 8'hFF - d;
      op_plus_one: r = d + 8'h01;
      minus_one: r = d - 8'h01;
      zero_sign_test: r = d;
      default: r = 8'hFF;
    endcase
    if (o inside {op_carry_sum, borrow_difference, carry_compare, immediate_borrow_difference,
                  op_reg_difference, twos_inverse}) m = MASK_ARITH;
    if (o == bitwise_invert) c = 1'b1;
    if (o == bitwise_invert) m = MASK_INVERT;
    if (o == op_plus_one) v = (d == 8'h7F);
    if (o == minus_one) v = (d == 8'h80);
    if (o == all_ones_register) m = NONE_MASK;
    e = (st0 & ~m) | ({2'b00, h, 1'b0, v, r[7], r == 8'h00, c} & m);
    cmp("dst_we", 16'(w), 16'(dst_we));
    if (w) cmp("dst_value", 16'(r), 16'(dst_value));
    cmp("status_we", 16'(m != 8'h00), 16'(status_we));
    if (m != 8'h00) cmp("status_value", 16'(e), 16'(status_value));
  endtask : byte_op
  initial begin
    repeat (5) @(posedge clock);
    #1;
    reset = 1'b0;
    set_status(8'h01);
    byte_op(op_carry_sum, 8'h7F, 8'h00, 8'h00);
    byte_op(op_reg_difference, 8'h10, 8'h20, 8'h00);
    byte_op(borrow_difference, 8'h00, 8'h00, 8'h00);
    byte_op(immediate_borrow_difference, 8'h80, 8'h00, 8'h01);
    set_status(8'hFF);
    byte_op(masked_constant_conjunction, 8'hF0, 8'h00, 8'h3C);
    byte_op(constant_disjunction, 8'h80, 8'h00, 8'h01);
    byte_op(exclusive_disjunction, 8'h5A, 8'h5A, 8'h00);
    byte_op(bitwise_invert, 8'h00, 8'h00, 8'h00);
    byte_op(set_bits_mask, 8'h01, 8'h00, 8'h80);
    byte_op(clear_bits_mask, 8'hFF, 8'h00, 8'h0F);
    byte_op(op_plus_one, 8'h7F, 8'h00, 8'h00);
    byte_op(minus_one, 8'h80, 8'h00, 8'h00);
    byte_op(zero_register, 8'h55, 8'h55, 8'h00);
    byte_op(zero_sign_test, 8'h80, 8'h00, 8'h00);
    byte_op(carry_compare, 8'h01, 8'h01, 8'h00);
    byte_op(twos_inverse, 8'h80, 8'h00, 8'h00);
    byte_op(all_ones_register, 8'h12, 8'h00, 8'h00);
    req.op = word_immediate_sum;
    req.pair = 16'hFFF0;
    req.word_imm = 6'h3F;
    issue(2);
    cmp("pair_value", 16'h002F, pair_value);
    cmp("pair_we", 16'h0001, 16'(pair_we));
    cmp("status_value", 16'((st0 & ~MASK_WORD) | 8'h01), 16'(status_value));
    req.op = word_immediate_difference;
    req.pair = 16'h0000;
    req.word_imm = 6'h01;
    issue(2);
    cmp("pair_value", 16'hFFFF, pair_value);
    cmp("status_value", 16'((st0 & ~MASK_WORD) | 8'h15), 16'(status_value));
    req.op = relative_call;
    req.offset = 12'hFFE;
    issue(3);
    cmp("pc_value", pc0 - 16'h0001, pc_value);
    cmp("push_value", pc0 + 16'h0001, push_value);
    cmp("push_we", 16'h0001, 16'(push_we));
    req.op = pointer_jump;
    z_pointer = 16'h1234;
    issue(2);
    cmp("pc_value", 16'h1234, pc_value);
    cmp("status_we", 16'h0000, 16'(status_we));
    req.op = pointer_call;
    z_pointer = 16'h0567;
    issue(3);
    cmp("pc_value", 16'h0567, pc_value);
    cmp("push_value", pc0 + 16'h0001, push_value);
    req.op = equal_skip;
    req.dst = 8'h33;
    req.src = 8'h33;
    req.next_long = 1'b1;
    issue(2);
    cmp("pc_value", pc0 + 16'h0003, pc_value);
    req.op = bit_clear_skip;
    req.dst = 8'h04;
    req.src = 8'h04;
    req.bit_sel = 3'h2;
    issue(1);
    cmp("pc_we", 16'h0000, 16'(pc_we));
    set_status(8'h00);
    req.op = interrupt_exit;
    stack_top = 16'h0ABC;
    issue(4);
    cmp("pc_value", 16'h0ABC, pc_value);
    cmp("status_value", 16'h0080, 16'(status_value));
    stop_test();
  end
endmodule : cabe_exec_tb
